// ### secp_pkg.sv
// constants and types shared by the serial eeprom command port
`default_nettype none
package secp_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // longest self-timed cycle, rounded down to whole clocks
  localparam int PROG_TIME_NS  = 5000000;
  localparam int PROG_CYCLES   = PROG_TIME_NS / CLK_PERIOD_NS;

  localparam int INSTR_BITS_X16 = 11;
  localparam int INSTR_BITS_X8  = 12;
  localparam int OPC_BITS       = 2;
  localparam int DATA_BITS_X16  = 16;
  localparam int DATA_BITS_X8   = 8;
  localparam int ARRAY_BYTES    = 512;
  localparam int ADDR_W         = 9;

  localparam logic [1:0] OPC_SPECIAL = 2'h0;
  localparam logic [1:0] OPC_WRITE   = 2'h1;
  localparam logic [1:0] OPC_READ    = 2'h2;
  localparam logic [1:0] OPC_ERASE   = 2'h3;

  localparam logic [1:0] SPC_DISABLE = 2'h0;
  localparam logic [1:0] SPC_FILL    = 2'h1;
  localparam logic [1:0] SPC_CLEAR   = 2'h2;
  localparam logic [1:0] SPC_ENABLE  = 2'h3;

  localparam logic [7:0] ERASED_BYTE = 8'hff;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_OPC  = 6'h02,
    ST_ADDR = 6'h04,
    ST_DATA = 6'h08,
    ST_READ = 6'h10,
    ST_DONE = 6'h20
  } secp_state_e;

  typedef enum logic [2:0] {
    JOB_NONE  = 3'h0,
    JOB_WRITE = 3'h1,
    JOB_ERASE = 3'h2,
    JOB_CLEAR = 3'h3,
    JOB_FILL  = 3'h4
  } secp_job_e;
endpackage : secp_pkg
`default_nettype wire

// ### secp_core.sv
// serial eeprom command port: decoder, array, self-timed programmer
`timescale 1ns/1ps
`default_nettype none

// Contract
// - instruction is 11 bits in x16 and 12 bits in x8, data excluded
// - input bits are taken on each rising serial clock edge
// - serial output floats except during read data or status
// - after a cycle starts, select high shows low busy, high ready
// - a one shifted in while status shows floats the output
// - start one, opcode, 8 or 9 address bits, then 16 or 8 data
// - opcode 10 plus address reads that location
// - opcode 11 erases a location, opcode 01 writes one word
// - opcode 00 top address bits: enable, disable, clear all, fill all
// - read sends one zero bit, then word msb first on rising edges
// - sequential read advances address and wraps to zero
// - only the first word of a sequential read has the zero bit
// - writing is disabled coming out of power-up
// - writes need enable first; disabled state ignores them
// - reads work whether writing is enabled or not
// - select falling after a program command starts its cycle
// - the cycle finishes alone, within five milliseconds
// - single write clears the location itself before storing
// - single erase leaves every bit of the location at one
// - clear all sets every bit of the array to one
// - fill all stores the word everywhere, no clear needed first
module secp_core #(
  parameter int PROG_CYCLES = secp_pkg::PROG_CYCLES
) (
  input  wire logic clk_in,
  input  wire logic reset_in,
  input  wire logic chip_select_in,
  input  wire logic serial_clock_in,
  input  wire logic serial_in_in,
  input  wire logic word_width_select_in,
  output logic      serial_out_out,
  output logic      serial_out_oe_n_out,
  output logic      busy_out
);
  import secp_pkg::*;

  localparam int TW = $clog2(PROG_CYCLES + 1);
  localparam logic [TW-1:0] TIMER_LAST = TW'(PROG_CYCLES - 1);
  localparam logic [8:0] IDX_LAST = 9'(ARRAY_BYTES - 1);

  // array holds bytes; a 16-bit word n sits at bytes 2n+1 (high), 2n
  logic [7:0] mem [ARRAY_BYTES];

  secp_state_e state, next_state;
  secp_job_e   job, next_job;
  secp_job_e   run_job;

  logic            sclk_prev, cs_prev;
  logic [4:0]      cnt, next_cnt;
  logic [1:0]      opc, next_opc;
  logic [8:0]      addr_sh, next_addr_sh;
  logic [15:0]     data_sh, next_data_sh;
  logic [8:0]      job_addr, next_job_addr;
  logic [15:0]     job_data, next_job_data, run_data;
  logic            write_enabled, next_enabled;
  logic [8:0]      rd_addr, next_rd_addr;
  logic [15:0]     out_sh, next_out_sh;
  logic            out_bit, next_out_bit;
  logic            reading, next_reading;
  logic            status_show, status_armed;
  logic            busy, walking;
  logic [TW-1:0]   timer;
  logic [8:0]      walk_idx, walk_end;

  wire logic        wide     = word_width_select_in;
  wire logic        sclk_rise = serial_clock_in & ~sclk_prev;
  wire logic        cs_rise  = chip_select_in & ~cs_prev;
  wire logic        cs_fall  = ~chip_select_in & cs_prev;
  wire logic        bit_take = sclk_rise & chip_select_in & ~busy;
  // address length follows from total instruction length
  wire logic [4:0]  addr_len = wide ? 5'(INSTR_BITS_X16 - 1 - OPC_BITS)
                                    : 5'(INSTR_BITS_X8 - 1 - OPC_BITS);
  wire logic [4:0]  data_len = wide ? 5'(DATA_BITS_X16) : 5'(DATA_BITS_X8);
  wire logic [8:0]  addr_next = {addr_sh[7:0], serial_in_in};
  wire logic [8:0]  addr_now  = wide ? {1'b0, addr_next[7:0]} : addr_next;
  wire logic [1:0]  spc_code  = wide ? addr_next[7:6] : addr_next[8:7];
  wire logic [15:0] data_next = {data_sh[14:0], serial_in_in};
  wire logic        last_opc  = cnt == 5'(OPC_BITS - 1);
  wire logic        last_addr = cnt == addr_len - 5'h01;
  wire logic        last_data = cnt == data_len - 5'h01;
  // x16 wraps inside 8 address bits, x8 inside 9
  wire logic [8:0]  rd_inc = wide ? {1'b0, rd_addr[7:0] + 8'h01} : rd_addr + 9'h001;

  wire logic        job_all   = (job == JOB_CLEAR) || (job == JOB_FILL);
  wire logic [8:0]  job_first = job_all ? 9'h000 : wide ? {job_addr[7:0], 1'b0} : job_addr;
  wire logic [8:0]  job_last  = job_all ? IDX_LAST : wide ? {job_addr[7:0], 1'b1} : job_addr;
  wire logic        cycle_start = cs_fall && (state == ST_DONE) &&
                                  (job != JOB_NONE) && write_enabled &&
                                  !busy;
  wire logic        run_ones = (run_job == JOB_ERASE) || (run_job == JOB_CLEAR);
  wire logic [7:0]  data_byte = (wide && walk_idx[0]) ? run_data[15:8] : run_data[7:0];
  wire logic [7:0]  walk_byte = run_ones ? ERASED_BYTE : data_byte;
  wire logic        drive     = reading | status_show;
  wire logic        drive_bit = status_show ? ~busy : out_bit;

  // reads are left-justified so the msb always leaves from bit 15
  function automatic logic [15:0] word_at(input logic [8:0] a,
                                          input logic       w);
    return w ? {mem[{a[7:0], 1'b1}], mem[{a[7:0], 1'b0}]} : {mem[a], 8'h00};
  endfunction : word_at

  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_opc      = opc;
    next_addr_sh  = addr_sh;
    next_data_sh  = data_sh;
    next_job      = job;
    next_job_addr = job_addr;
    next_job_data = job_data;
    next_enabled  = write_enabled;
    next_rd_addr  = rd_addr;
    next_out_sh   = out_sh;
    next_out_bit  = out_bit;
    next_reading  = reading;
    if (!chip_select_in || busy) begin
      // a job is only posted at completion, so dropping it here is safe
      next_state   = ST_IDLE;
      next_cnt     = 5'h00;
      next_reading = 1'b0;
      if (!chip_select_in) begin
        next_job = JOB_NONE;
      end
    end else if (sclk_rise) begin
      case (state)
        ST_IDLE: begin
          if (serial_in_in) begin
            next_state = ST_OPC;
            next_cnt   = 5'h00;
          end
        end
        ST_OPC: begin
          next_opc = {opc[0], serial_in_in};
          next_cnt = cnt + 5'h01;
          if (last_opc) begin
            next_state = ST_ADDR;
            next_cnt   = 5'h00;
          end
        end
        ST_ADDR: begin
          next_addr_sh = addr_next;
          next_cnt     = cnt + 5'h01;
          if (last_addr) begin
            next_cnt   = 5'h00;
            next_state = ST_DONE;
            case (opc)
              OPC_READ: begin
                // no check of write_enabled on this path
                next_state   = ST_READ;
                next_reading = 1'b1;
                next_out_bit = 1'b0;
                next_out_sh  = word_at(addr_now, wide);
                next_rd_addr = addr_now;
              end
              OPC_WRITE: begin
                next_state    = ST_DATA;
                next_job_addr = addr_now;
              end
              OPC_ERASE: begin
                next_job      = JOB_ERASE;
                next_job_addr = addr_now;
              end
              default: begin
                case (spc_code)
                  SPC_ENABLE:  next_enabled = 1'b1;
                  SPC_DISABLE: next_enabled = 1'b0;
                  SPC_CLEAR:   next_job     = JOB_CLEAR;
                  default:     next_state   = ST_DATA;
                endcase
              end
            endcase
          end
        end
        ST_DATA: begin
          next_data_sh = data_next;
          next_cnt     = cnt + 5'h01;
          if (last_data) begin
            next_cnt      = 5'h00;
            next_state    = ST_DONE;
            next_job_data = data_next;
            next_job      = (opc == OPC_WRITE) ? JOB_WRITE : JOB_FILL;
          end
        end
        ST_READ: begin
          next_out_bit = out_sh[15];
          next_out_sh  = {out_sh[14:0], 1'b0};
          next_cnt     = cnt + 5'h01;
          if (last_data) begin
            // next word follows straight on, no zero bit
            next_cnt     = 5'h00;
            next_rd_addr = rd_inc;
            next_out_sh  = word_at(rd_inc, wide);
          end
        end
        ST_DONE: next_state = ST_DONE;
        default: next_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state         <= ST_IDLE;
      cnt           <= 5'h00;
      opc           <= 2'h0;
      addr_sh       <= 9'h000;
      data_sh       <= 16'h0000;
      job           <= JOB_NONE;
      job_addr      <= 9'h000;
      job_data      <= 16'h0000;
      write_enabled <= 1'b0;
      rd_addr       <= 9'h000;
      out_sh        <= 16'h0000;
      out_bit       <= 1'b0;
      reading       <= 1'b0;
    end else begin
      state         <= next_state;
      cnt           <= next_cnt;
      opc           <= next_opc;
      addr_sh       <= next_addr_sh;
      data_sh       <= next_data_sh;
      job           <= next_job;
      job_addr      <= next_job_addr;
      job_data      <= next_job_data;
      write_enabled <= next_enabled;
      rd_addr       <= next_rd_addr;
      out_sh        <= next_out_sh;
      out_bit       <= next_out_bit;
      reading       <= next_reading;
    end
  end

  // pin edges; inputs are already in this clock domain
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      sclk_prev <= 1'b0;
      cs_prev   <= 1'b0;
    end else begin
      sclk_prev <= serial_clock_in;
      cs_prev <= chip_select_in;
    end
  end

  // status: later assignments win, so a cycle start beats a clear
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      status_show  <= 1'b0;
      status_armed <= 1'b0;
    end else begin
      if (!chip_select_in && status_show) begin
        status_armed <= 1'b0;
      end
      if (!chip_select_in) begin
        status_show <= 1'b0;
      end else if (cs_rise && status_armed) begin
        status_show <= 1'b1;
      end else if (sclk_rise && status_show && serial_in_in) begin
        status_show  <= 1'b0;
        status_armed <= 1'b0;
      end
      if (cycle_start) begin
        status_armed <= 1'b1;
      end
    end
  end

  // self-timed programmer; needs no serial clock once running
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      busy     <= 1'b0;
      timer    <= '0;
      walking  <= 1'b0;
      walk_idx <= 9'h000;
      walk_end <= 9'h000;
      run_job  <= JOB_NONE;
      run_data <= 16'h0000;
    end else if (cycle_start) begin
      busy     <= 1'b1;
      timer    <= '0;
      walking  <= 1'b1;
      walk_idx <= job_first;
      walk_end <= job_last;
      run_job  <= job;
      run_data <= job_data;
    end else if (busy) begin
      timer <= timer + 1'b1;
      if (timer == TIMER_LAST) begin
        busy <= 1'b0;
      end
      if (walking) begin
        walk_idx <= walk_idx + 9'h001;
        walking  <= walk_idx != walk_end;
      end
    end
  end

  // whole-byte overwrite is the auto-clear; one byte per clock
  always_ff @(posedge clk_in) begin
    if (busy && walking) mem[walk_idx] <= walk_byte;
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      serial_out_out      <= 1'b0;
      serial_out_oe_n_out <= 1'b1;
    end else begin
      serial_out_out      <= drive_bit;
      serial_out_oe_n_out <= ~drive;
    end
  end

  assign busy_out = busy;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  sequence s_read_done;
    bit_take && (state == ST_ADDR) && last_addr && (opc == OPC_READ);
  endsequence
  sequence s_zero_out;
    reading && !out_bit ##1 !serial_out_out && !serial_out_oe_n_out;
  endsequence
  chk_idle_float: assert property (
    !chip_select_in [*2] |=> serial_out_oe_n_out)
    else $error("output driven while deselected");
  chk_status_level: assert property (
    status_show && chip_select_in |=> serial_out_out == !$past(busy)
                                      && !serial_out_oe_n_out)
    else $error("status level wrong");
  chk_status_dismiss: assert property (
    sclk_rise && chip_select_in && status_show && serial_in_in
    |=> !status_show ##1 serial_out_oe_n_out || reading)
    else $error("status not floated by a one");
  chk_dummy_zero: assert property (
    s_read_done |=> s_zero_out)
    else $error("leading zero missing");
  chk_read_wrap: assert property (
    bit_take && state == ST_READ && last_data && rd_addr == IDX_LAST
    && !wide |=> rd_addr == 9'h000)
    else $error("sequential read did not wrap");
  chk_power_locked: assert property (
    $fell(reset_in) |-> !write_enabled)
    else $error("writing enabled after reset");
  chk_locked_ignore: assert property (
    cs_fall && !busy && !write_enabled |=> !busy [*2])
    else $error("program cycle while disabled");
  chk_cycle_start: assert property (
    cycle_start |=> busy && walk_idx == $past(job_first))
    else $error("cycle did not start on select fall");
  chk_cycle_bound: assert property (
    busy && timer == TIMER_LAST |=> !busy && !walking)
    else $error("program cycle overran");
  chk_abandon: assert property (
    cs_fall && state != ST_DONE && !busy |=> !busy && job == JOB_NONE)
    else $error("partial instruction acted on");
endmodule : secp_core
`default_nettype wire

// ### secp_core_unused_guard.sv
// holds no logic; the whole block lives in secp_core
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### secp_host.sv
// host side model driving the four-wire serial link
`timescale 1ns/1ps
`default_nettype none
module secp_host #(
  parameter int POWERUP_WAIT = 20
) (
  input  wire logic clk_in,
  input  wire logic serial_out_in,
  input  wire logic serial_out_oe_n_in,
  output var logic  chip_select_out,
  output var logic  serial_clock_out,
  output var logic  serial_in_out
);
  logic        last_o;
  logic        last_z;
  logic [31:0] rx;

  initial begin
    chip_select_out = 1'b0;
    serial_clock_out = 1'b0;
    serial_in_out = 1'b0;
    last_o = 1'b0;
    last_z = 1'b1;
    rx = 32'h0;
  end

  // scaled down: a real supply settle wait would dwarf the run
  task automatic powerup;
    repeat (POWERUP_WAIT) @(posedge clk_in);
  endtask : powerup

  task automatic frame_begin;
    @(posedge clk_in);
    chip_select_out <= 1'b1;
  endtask : frame_begin

  // serial clock stands still low outside this task
  task automatic bit_io(input logic b);
    @(posedge clk_in);
    serial_clock_out <= 1'b1;
    serial_in_out    <= b;
    repeat (2) @(posedge clk_in);
    serial_clock_out <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    last_z = serial_out_oe_n_in;
    // a floating line is not trusted to hold its last level
    last_o = last_z ? ~last_o : serial_out_in;
    rx = {rx[30:0], last_o};
  endtask : bit_io

  task automatic send(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      bit_io(v[i]);
    end
  endtask : send

  task automatic frame_end;
    @(posedge clk_in);
    chip_select_out <= 1'b0;
    serial_in_out   <= ~serial_in_out;
    repeat (30) @(posedge clk_in);
  endtask : frame_end

  task automatic wait_ready(input logic dismiss, output logic saw_busy, output logic ready);
    saw_busy = 1'b0;
    ready = 1'b0;
    @(posedge clk_in);
    chip_select_out <= 1'b1;
    repeat (3) @(posedge clk_in);
    for (int n = 0; n < 2000 && !ready; n++) begin
      #1;
      if (serial_out_oe_n_in === 1'b0 && serial_out_in === 1'b0) saw_busy = 1'b1;
      if (serial_out_oe_n_in === 1'b0 && serial_out_in === 1'b1) ready = 1'b1;
      @(posedge clk_in);
    end
    if (dismiss) bit_io(1'b1);
    frame_end();
  endtask : wait_ready
endmodule : secp_host
`default_nettype wire

// ### testbench.sv
// self-checking testbench for the serial eeprom command port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import secp_pkg::*;
  localparam int PROG = 600;
  logic clk_in;
  logic reset_in;
  logic x16;
  logic cs;
  logic sck;
  logic sin;
  logic sout;
  logic oe_n;
  logic busy;
  int   n_fail;
  int   checked;

  secp_core #(.PROG_CYCLES(PROG)) secp_core_inst (
    .clk_in(clk_in), .reset_in(reset_in), .chip_select_in(cs), .serial_clock_in(sck),
    .serial_in_in(sin), .word_width_select_in(x16), .serial_out_out(sout),
    .serial_out_oe_n_out(oe_n), .busy_out(busy));
  secp_host secp_host_inst (
    .clk_in(clk_in), .serial_out_in(sout), .serial_out_oe_n_in(oe_n),
    .chip_select_out(cs), .serial_clock_out(sck), .serial_in_out(sin));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic wrap_up;
    $display("checked %0d, failed %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up

  task automatic cmp_bit(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask : cmp_bit

  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : cmp_word

  function automatic int ib();
    return x16 ? INSTR_BITS_X16 : INSTR_BITS_X8;
  endfunction : ib

  function automatic int db();
    return x16 ? DATA_BITS_X16 : DATA_BITS_X8;
  endfunction : db

  function automatic logic [31:0] ins(input logic [1:0] opc, input logic [8:0] a);
    return x16 ? {21'h0, 1'b1, opc, a[7:0]} : {20'h0, 1'b1, opc, a};
  endfunction : ins

  // special commands live in the two top address bits
  function automatic logic [8:0] spc(input logic [1:0] code);
    return x16 ? {1'b0, code, 6'h0} : {code, 7'h0};
  endfunction : spc

  task automatic prog(input logic [1:0] opc, input logic [8:0] a, input logic [15:0] d,
                      input logic wd, input logic run, input logic dismiss);
    logic sb;
    logic rdy;
    secp_host_inst.frame_begin();
    secp_host_inst.send(ins(opc, a), ib());
    if (wd) secp_host_inst.send({16'h0, d}, db());
    secp_host_inst.frame_end();
    #1;
    cmp_bit(busy, run, "busy after select fall");
    if (run) begin
      secp_host_inst.wait_ready(dismiss, sb, rdy);
      cmp_bit(sb, 1'b1, "status busy seen");
      cmp_bit(rdy, 1'b1, "status ready seen");
      if (dismiss) cmp_bit(secp_host_inst.last_z, 1'b1, "status dismissed");
    end
  endtask : prog

  task automatic rd(input logic [8:0] a, input logic [15:0] e0, input logic [15:0] e1);
    logic [15:0] m;
    m = x16 ? 16'hffff : 16'h00ff;
    secp_host_inst.frame_begin();
    secp_host_inst.send(ins(OPC_READ, a), ib());
    cmp_bit(secp_host_inst.last_z, 1'b0, "read drives");
    cmp_bit(secp_host_inst.last_o, 1'b0, "leading zero");
    secp_host_inst.send(32'h0, db());
    cmp_word(secp_host_inst.rx[15:0] & m, e0 & m, "first word");
    secp_host_inst.send(32'h0, db());
    cmp_word(secp_host_inst.rx[15:0] & m, e1 & m, "next word");
    secp_host_inst.frame_end();
    #1;
    cmp_bit(oe_n, 1'b1, "float after read");
  endtask : rd

  task automatic t_disabled;
    cmp_bit(oe_n, 1'b1, "idle float");
    prog(OPC_WRITE, 9'h0, 16'h1234, 1'b1, 1'b0, 1'b0);
    $display("test disabled done");
  endtask : t_disabled

  task automatic t_clear;
    prog(OPC_SPECIAL, spc(SPC_ENABLE), 16'h0, 1'b0, 1'b0, 1'b0);
    prog(OPC_SPECIAL, spc(SPC_CLEAR), 16'h0, 1'b0, 1'b1, 1'b0);
    rd(9'h80, 16'hffff, 16'hffff);
    $display("test clear done");
  endtask : t_clear

  task automatic t_seq;
    prog(OPC_WRITE, 9'hff, 16'ha5c3, 1'b1, 1'b1, 1'b1);
    prog(OPC_WRITE, 9'hff, 16'h5a3c, 1'b1, 1'b1, 1'b0);
    prog(OPC_WRITE, 9'h0, 16'h0ff0, 1'b1, 1'b1, 1'b0);
    rd(9'hff, 16'h5a3c, 16'h0ff0);
    $display("test sequential done");
  endtask : t_seq

  task automatic t_erase_abort;
    prog(OPC_ERASE, 9'hff, 16'h0, 1'b0, 1'b1, 1'b0);
    secp_host_inst.frame_begin();
    secp_host_inst.send(ins(OPC_WRITE, 9'h0), ib());
    secp_host_inst.send(32'h0, 8);
    secp_host_inst.frame_end();
    #1;
    cmp_bit(busy, 1'b0, "abandoned write idle");
    rd(9'hff, 16'hffff, 16'h0ff0);
    $display("test erase and abort done");
  endtask : t_erase_abort

  task automatic t_fill_protect;
    prog(OPC_SPECIAL, spc(SPC_FILL), 16'h0f0f, 1'b1, 1'b1, 1'b0);
    prog(OPC_SPECIAL, spc(SPC_DISABLE), 16'h0, 1'b0, 1'b0, 1'b0);
    prog(OPC_ERASE, 9'h7, 16'h0, 1'b0, 1'b0, 1'b0);
    rd(9'h7, 16'h0f0f, 16'h0f0f);
    $display("test fill and protect done");
  endtask : t_fill_protect

  task automatic t_x8;
    @(posedge clk_in);
    x16 <= 1'b0;
    // prog arguments are worked out at the call, so the width must settle first
    @(posedge clk_in);
    prog(OPC_SPECIAL, spc(SPC_ENABLE), 16'h0, 1'b0, 1'b0, 1'b0);
    prog(OPC_WRITE, 9'h1ff, 16'h0081, 1'b1, 1'b1, 1'b0);
    rd(9'h1ff, 16'h0081, 16'h000f);
    $display("test byte mode done");
  endtask : t_x8

  initial begin
    n_fail = 0;
    checked = 0;
    reset_in = 1'b1;
    x16 = 1'b1;
    repeat (12) @(posedge clk_in);
    reset_in <= 1'b0;
    secp_host_inst.powerup();
    t_disabled();
    t_clear();
    t_seq();
    t_erase_abort();
    t_fill_protect();
    t_x8();
    wrap_up();
  end

  // all programs together stay well under this span
  initial begin
    repeat (60000) @(posedge clk_in);
    n_fail++;
    $display("Error at %0t: run did not finish in time", $time);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
